/* src/hcrh_pkg.sv */
// constants, types and request codes shared by the hub class request handler
package hcrh_pkg;

	localparam int NUM_PORTS = 4;

	// setup packet fields as presented by the control endpoint
	typedef struct packed {
		logic [7:0] req_type;
		logic [7:0] request;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} hcrh_setup_s;

	// per-port state from the port logic, same clock
	typedef struct packed {
		logic connect;
		logic enabled;
		logic suspended;
		logic over_current;
		logic reset_active;
		logic powered;
		logic low_speed;
		logic resume_done;
		logic reset_done;
	} hcrh_port_in_s;

	typedef enum logic [1:0] {
		HCRH_IDLE = 2'b01,
		HCRH_SEND = 2'b10
	} hcrh_state_e;

	typedef logic [1:0] hcrh_kind_t;
	localparam hcrh_kind_t KIND_DESC = 2'h0;
	localparam hcrh_kind_t KIND_STAT = 2'h1;
	localparam hcrh_kind_t KIND_BUS = 2'h2;

	// request type and request codes
	localparam logic [7:0] RT_HUB_OUT = 8'h20;
	localparam logic [7:0] RT_PORT_OUT = 8'h23;
	localparam logic [7:0] RT_HUB_IN = 8'ha0;
	localparam logic [7:0] RT_PORT_IN = 8'ha3;
	localparam logic [7:0] RQ_GET_STATUS = 8'h00;
	localparam logic [7:0] RQ_CLEAR_FEATURE = 8'h01;
	localparam logic [7:0] RQ_GET_BUS_STATE = 8'h02;
	localparam logic [7:0] RQ_GET_DESC = 8'h06;
	localparam logic [7:0] DESC_TYPE_HUB = 8'h29;

	// feature selectors
	localparam logic [15:0] HSEL_LOCAL_PWR = 16'h0000;
	localparam logic [15:0] HSEL_OVER_CUR = 16'h0001;
	localparam logic [15:0] PSEL_ENABLE = 16'h0001;
	localparam logic [15:0] PSEL_SUSPEND = 16'h0002;
	localparam logic [15:0] PSEL_POWER = 16'h0008;
	localparam logic [15:0] PSEL_C_FIRST = 16'h0010;
	localparam logic [15:0] PSEL_C_LAST = 16'h0014;

	// answer lengths in bytes
	localparam logic [15:0] DESC_LEN = 16'h0009;
	localparam logic [15:0] STAT_LEN = 16'h0004;
	localparam logic [15:0] BUS_LEN = 16'h0001;

	// hub descriptor, byte 0 in element 0
	localparam logic [8:0][7:0] HUB_DESC = {
		8'h1e, 8'h00, 8'h64, 8'h32, 8'h00, 8'h09, 8'h04, 8'h29, 8'h09
	};

	// register map of the software port
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HUB = 8'h04;
	localparam logic [7:0] REG_LINE = 8'h08;
	localparam logic [7:0] REG_PCHG = 8'h0c;
	localparam logic CTRL_RESET = 1'b1;

	// pin synchroniser: [3:0] minus, [7:4] plus, [8] supply good, [9] bus powered strap
	localparam int SYNC_W = 10;
	localparam logic [SYNC_W-1:0] SYNC_RST = 10'h100;

endpackage

/* src/hcrh_sync.sv */
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module hcrh_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous pins
	output logic [W-1:0] q // filtered, synchronous
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_next;

	// s1 feeds only s2; the agreement check looks at s2 and s3
	assign q_next = (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			q <= RST_VAL;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q <= q_next;
		end
	end

endmodule

`default_nettype wire

/* src/hcrh_handler.sv */
// hub class request handler: clears, bus state, hub descriptor and status words
//
// Contract
// R01 - clear hub feature selector 0 clears the local power change bit
// R02 - clear hub feature selector 1 is stalled, no global over-current
// R03 - clear port feature acts on enable, suspend, power and change bits; others stall
// R04 - clear port feature on port 0 or above 4 stalls, changes nothing
// R05 - at each EOF2 sample line state of ports 1 to 4 into registers; the code samples only while ctrl_reg (REG_CTRL bit 0) is set
// R06 - line-state byte: minus line bit 0, plus line bit 1, rest zero
// R07 - bus state read on port 0 or above 4 stalls
// R08 - descriptor read shorter than 9 returns only the first bytes
// R09 - descriptor read longer than 9 pads with zero bytes
// R10 - hub status read returns status word then change word
// R11 - self powered: status bit 0 is 0 supply good, 1 supply lost
// R12 - hub status bits 1 to 15 read zero
// R13 - bus powered: hub status bit 0 reads zero
// R14 - hub change bit 0 sets on local power change, holds until cleared
// R15 - hub change bits 1 to 15 read zero
// R16 - bus powered: hub change bit 0 reads zero
// R17 - port status read returns status then change word; bad port stalls
// R18 - port status bits 0,1,2: connect, enabled, suspended
// R19 - port status bit 3 is over-current, and that port's power is cut
// R20 - port status bit 4 is reset signalling; bits 5 to 7 zero
// R21 - port status bit 8 power, bit 9 low speed, bits 10 to 15 zero
// R22 - port change bits 0 to 4 flag connect, enable, resume, over-current, reset
// R23 - change bits latch until the matching clear; a same-cycle event wins
`timescale 1ns/1ps
`default_nettype none

module hcrh_handler
	import hcrh_pkg::*;
(
	input wire logic mclk, // 50 MHz system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [31:0] reg_rdata, // read data, cycle after reg_rd
	input wire logic req_valid, // setup packet present, one cycle
	input wire hcrh_setup_s req_setup, // setup packet fields
	output logic req_busy, // request in progress
	output logic req_stall, // answer with stall, one cycle
	output logic req_done, // request finished, one cycle
	output logic tx_valid, // data byte offered
	output logic [7:0] tx_data, // data byte
	output logic tx_last, // final byte of the answer
	input wire logic tx_ready, // endpoint takes the byte
	input wire logic eof2_pulse, // frame EOF2 point, one cycle
	input wire logic [3:0] minus_line_pin, // downstream minus lines
	input wire logic [3:0] plus_line_pin, // downstream plus lines
	input wire logic local_pwr_good_pin, // local supply good
	input wire logic bus_powered_pin, // strap: high for bus powered
	input wire hcrh_port_in_s [3:0] port_in, // port logic state
	output logic [3:0] port_disable, // disable port, one cycle
	output logic [3:0] port_resume, // end suspend, one cycle
	output logic [3:0] port_power_off // cut port power, one cycle
);

	hcrh_state_e state_reg;
	hcrh_state_e state_next;
	logic [SYNC_W-1:0] pins;
	logic ctrl_reg;
	logic [3:0][1:0] line_reg;
	logic lp_prev_reg;
	logic hub_chg_reg;
	logic hub_chg_next;
	hcrh_kind_t kind_reg;
	logic [3:0][7:0] snap_reg;
	logic [15:0] len_reg;
	logic [15:0] idx_reg;
	wire [15:0] stat_w [NUM_PORTS];
	wire [4:0] chg5 [NUM_PORTS];

	hcrh_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.d({bus_powered_pin, local_pwr_good_pin, plus_line_pin, minus_line_pin}),
		.q(pins)
	);

	wire [3:0] minus_s = pins[3:0];
	wire [3:0] plus_s = pins[7:4];
	wire pwr_good_s = pins[8];
	wire bus_pwr_s = pins[9];

	// request decode
	hcrh_setup_s s;
	assign s = req_setup;
	wire take = req_valid && (state_reg == HCRH_IDLE);
	wire [7:0] pnum = s.index[7:0];
	wire port_ok = (s.index[15:8] == 8'h00) && (pnum != 8'h00) && (pnum <= 8'(NUM_PORTS));
	wire [1:0] pidx = 2'(pnum - 8'h01);
	wire is_clr_hub = (s.req_type == RT_HUB_OUT) && (s.request == RQ_CLEAR_FEATURE);
	wire is_clr_port = (s.req_type == RT_PORT_OUT) && (s.request == RQ_CLEAR_FEATURE);
	wire is_bus = (s.req_type == RT_PORT_IN) && (s.request == RQ_GET_BUS_STATE);
	wire is_desc = (s.req_type == RT_HUB_IN) && (s.request == RQ_GET_DESC)
		&& (s.value[15:8] == DESC_TYPE_HUB);
	wire is_hstat = (s.req_type == RT_HUB_IN) && (s.request == RQ_GET_STATUS);
	wire is_pstat = (s.req_type == RT_PORT_IN) && (s.request == RQ_GET_STATUS);
	wire sel_chg = (s.value >= PSEL_C_FIRST) && (s.value <= PSEL_C_LAST);
	wire [4:0] clr_bits = sel_chg ? 5'(5'h01 << s.value[2:0]) : 5'h00;
	wire sel_port_ok = (s.value == PSEL_ENABLE) || (s.value == PSEL_SUSPEND)
		|| (s.value == PSEL_POWER) || sel_chg; // see R03
	wire ok_clr_hub = is_clr_hub && (s.value == HSEL_LOCAL_PWR); // see R01 see R02
	wire ok_clr_port = is_clr_port && port_ok && sel_port_ok; // see R03 see R04
	wire ok_bus = is_bus && port_ok; // see R07
	wire ok_pstat = is_pstat && port_ok; // see R17
	wire ok_data = is_desc || is_hstat || ok_pstat || ok_bus;
	wire do_stall = take && !(ok_clr_hub || ok_clr_port || ok_data);
	wire do_clr_hub = take && ok_clr_hub;
	wire do_clr_port = take && ok_clr_port;
	wire do_data = take && ok_data;
	wire do_nodata = take && (ok_clr_hub || ok_clr_port);

	// hub status and change words
	wire lp_status = !bus_pwr_s && !pwr_good_s; // see R11 see R13
	wire lp_event = !bus_pwr_s && (lp_status != lp_prev_reg); // see R14
	assign hub_chg_next = lp_event || (hub_chg_reg && !do_clr_hub); // see R01 see R23
	wire hub_chg_rep = hub_chg_reg && !bus_pwr_s; // see R16
	wire [31:0] hub_word = {15'h0000, hub_chg_rep, 15'h0000, lp_status}; // see R10 see R12 see R15

	// answer lengths and snapshot taken when the request is accepted
	wire [15:0] len_next = is_desc ? s.length // see R08 see R09
		: ok_bus ? ((s.length < BUS_LEN) ? s.length : BUS_LEN)
		: ((s.length < STAT_LEN) ? s.length : STAT_LEN);
	wire hcrh_kind_t kind_next = is_desc ? KIND_DESC : ok_bus ? KIND_BUS : KIND_STAT;
	wire [31:0] snap_next = is_hstat ? hub_word // see R10
		: ok_bus ? {24'h000000, 6'h00, line_reg[pidx]}
		: {11'h000, chg5[pidx], stat_w[pidx]}; // see R17

	// byte selection while sending
	wire [7:0] desc_byte = (idx_reg < DESC_LEN) ? HUB_DESC[idx_reg[3:0]] : 8'h00; // see R09
	wire [7:0] cur_byte = (kind_reg == KIND_DESC) ? desc_byte : snap_reg[idx_reg[1:0]];
	wire load_byte = (state_reg == HCRH_SEND) && (!tx_valid || tx_ready);
	wire more = idx_reg != len_reg;
	wire finish = load_byte && !more;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HCRH_IDLE: begin
				if (do_data) begin
					state_next = HCRH_SEND;
				end
			end
			HCRH_SEND: begin
				if (finish) begin
					state_next = HCRH_IDLE;
				end
			end
			default: begin
				state_next = HCRH_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= HCRH_IDLE;
			req_busy <= 1'b0;
			req_stall <= 1'b0;
			req_done <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_busy <= (state_next != HCRH_IDLE);
			req_stall <= do_stall;
			req_done <= do_nodata || finish;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			kind_reg <= KIND_DESC;
			snap_reg <= '0;
			len_reg <= 16'h0000;
			idx_reg <= 16'h0000;
		end else if (do_data) begin
			kind_reg <= kind_next;
			snap_reg <= snap_next;
			len_reg <= len_next;
			idx_reg <= 16'h0000;
		end else if (load_byte && more) begin
			idx_reg <= 16'(idx_reg + 16'h0001);
		end
	end

	// byte stage: a new byte loads when the stage is empty or its byte is taken
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
		end else if (load_byte) begin
			tx_valid <= more;
			tx_data <= more ? cur_byte : 8'h00;
			tx_last <= more && (16'(idx_reg + 16'h0001) == len_reg);
		end
	end

	// supply change tracking and line sampling
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lp_prev_reg <= 1'b0;
			hub_chg_reg <= 1'b0;
			line_reg <= '0;
		end else begin
			lp_prev_reg <= lp_status;
			hub_chg_reg <= hub_chg_next;
			if (eof2_pulse && ctrl_reg) begin
				for (int i = 0; i < NUM_PORTS; i++) begin
					line_reg[i] <= {plus_s[i], minus_s[i]}; // see R05 see R06
				end
			end
		end
	end

	// per-port change bits and port commands
	for (genvar gi = 0; gi < NUM_PORTS; gi++) begin : g_port
		localparam logic [1:0] PI = 2'(gi);
		logic [2:0] prev_reg;
		logic [4:0] chg_reg;
		logic dis_reg;
		logic res_reg;
		logic off_reg;
		hcrh_port_in_s p;
		assign p = port_in[gi];
		wire hit = do_clr_port && (pidx == PI);
		wire oc_rise = p.over_current && !prev_reg[2];
		wire [4:0] evt = {p.reset_done, p.over_current ^ prev_reg[2], p.resume_done,
			p.enabled ^ prev_reg[1], p.connect ^ prev_reg[0]}; // see R22
		wire [4:0] clr = hit ? clr_bits : 5'h00;
		wire [4:0] chg_next = evt | (chg_reg & ~clr); // see R23

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				prev_reg <= 3'h0;
				chg_reg <= 5'h00;
				dis_reg <= 1'b0;
				res_reg <= 1'b0;
				off_reg <= 1'b0;
			end else begin
				prev_reg <= {p.over_current, p.enabled, p.connect};
				chg_reg <= chg_next;
				dis_reg <= hit && (s.value == PSEL_ENABLE); // see R03
				res_reg <= hit && (s.value == PSEL_SUSPEND); // see R03
				// power is cut on the over-current edge as well as on request
				off_reg <= (hit && (s.value == PSEL_POWER)) || oc_rise; // see R03 see R19
			end
		end

		assign stat_w[gi] = {6'h00, p.low_speed, p.powered, 3'h0, p.reset_active,
			p.over_current, p.suspended, p.enabled, p.connect}; // see R18 see R20 see R21
		assign chg5[gi] = chg_reg;
		assign port_disable[gi] = dis_reg;
		assign port_resume[gi] = res_reg;
		assign port_power_off[gi] = off_reg;
	end

	// software register port
	wire [31:0] line_word = {6'h00, line_reg[3], 6'h00, line_reg[2],
		6'h00, line_reg[1], 6'h00, line_reg[0]};
	wire [31:0] pchg_word = {12'h000, chg5[3], chg5[2], chg5[1], chg5[0]};
	wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {31'h00000000, ctrl_reg}
		: (reg_addr == REG_HUB) ? hub_word
		: (reg_addr == REG_LINE) ? line_word
		: (reg_addr == REG_PCHG) ? pchg_word : 32'h00000000;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_RESET;
			reg_rdata <= 32'h00000000;
		end else begin
			if (reg_wr && (reg_addr == REG_CTRL)) begin
				ctrl_reg <= reg_wdata[0];
			end
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// checks
	property p_hub_oc_stall;
		@(posedge mclk) disable iff (!reset_n)
		(take && is_clr_hub && (s.value == HSEL_OVER_CUR)) |=> req_stall && !req_done;
	endproperty
	a_hub_oc_stall: assert property (p_hub_oc_stall) // see R02
		else $error("global over-current clear not stalled");

	property p_bad_port_stall;
		@(posedge mclk) disable iff (!reset_n)
		(take && (is_clr_port || is_bus || is_pstat) && !port_ok)
			|=> req_stall && (port_disable == 4'h0) && (port_resume == 4'h0) && !req_busy;
	endproperty
	a_bad_port_stall: assert property (p_bad_port_stall) // see R04
		else $error("bad port number not stalled");

	property p_hub_chg_clear;
		@(posedge mclk) disable iff (!reset_n)
		(do_clr_hub && !lp_event) |=> !hub_chg_reg;
	endproperty
	a_hub_chg_clear: assert property (p_hub_chg_clear) // see R01
		else $error("local power change not cleared");

	property p_hub_chg_hold;
		@(posedge mclk) disable iff (!reset_n)
		(hub_chg_reg && !do_clr_hub) |=> hub_chg_reg;
	endproperty
	a_hub_chg_hold: assert property (p_hub_chg_hold) // see R14
		else $error("local power change lost without clear");

	property p_bus_pwr_zero;
		@(posedge mclk) disable iff (!reset_n)
		bus_pwr_s |-> (hub_word[0] == 1'b0) && (hub_word[16] == 1'b0);
	endproperty
	a_bus_pwr_zero: assert property (p_bus_pwr_zero) // see R13
		else $error("bus powered hub reports local power");

	property p_line_sample;
		@(posedge mclk) disable iff (!reset_n)
		(eof2_pulse && ctrl_reg) |=> (line_reg[2] == {$past(plus_s[2]), $past(minus_s[2])});
	endproperty
	a_line_sample: assert property (p_line_sample) // see R05
		else $error("line state not sampled at EOF2");

	property p_desc_first;
		@(posedge mclk) disable iff (!reset_n)
		(take && is_desc && (s.length != 16'h0000)) |-> ##2 (tx_valid && (tx_data == HUB_DESC[0]));
	endproperty
	a_desc_first: assert property (p_desc_first) // see R08
		else $error("descriptor does not start at byte 0");

	property p_desc_pad;
		@(posedge mclk) disable iff (!reset_n)
		(load_byte && more && (kind_reg == KIND_DESC) && (idx_reg >= DESC_LEN))
			|=> tx_valid && (tx_data == 8'h00);
	endproperty
	a_desc_pad: assert property (p_desc_pad) // see R09
		else $error("descriptor padding not zero");

	property p_oc_power_off;
		@(posedge mclk) disable iff (!reset_n)
		$rose(port_in[2].over_current) |=> port_power_off[2] ##1 (chg5[2][3] || $past(do_clr_port));
	endproperty
	a_oc_power_off: assert property (p_oc_power_off) // see R19
		else $error("over-current did not cut power or flag change");

endmodule

`default_nettype wire

/* test/hcrh_host_model.sv */
// byte sink standing for the upstream host on the data stage
`timescale 1ns/1ps
`default_nettype none

module hcrh_host_model (
	input wire logic mclk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic start, // new request, empties the capture
	input wire logic slow, // high: ready only every other cycle
	input wire logic tx_valid, // byte offered
	input wire logic [7:0] tx_data, // byte
	input wire logic tx_last, // byte is the final one
	output logic tx_ready, // byte taken
	output logic [15:0][7:0] rx_bytes, // captured bytes, first in 0
	output logic [4:0] rx_count, // bytes taken since start
	output logic [4:0] last_idx // position of the byte marked last
);
	// a slow host exercises the hold of tx_data across refused cycles
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_ready <= 1'b0;
			rx_count <= 5'h00;
			rx_bytes <= '0;
			last_idx <= 5'h1f;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (start) begin
				rx_count <= 5'h00;
				last_idx <= 5'h1f;
			end else if (tx_valid && tx_ready) begin
				rx_bytes[rx_count[3:0]] <= tx_data;
				rx_count <= rx_count + 5'h01;
				if (tx_last) begin
					last_idx <= rx_count;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* test/hcrh_handler_tb_top.sv */
// self-checking testbench for the hub class request handler
`timescale 1ns/1ps
`default_nettype none

module hcrh_handler_tb_top
	import hcrh_pkg::*;
;
	logic mclk, reset_n, reg_wr, reg_rd, req_valid, req_busy, req_stall, req_done;
	logic tx_valid, tx_last, tx_ready, eof2_pulse, local_pwr_good_pin, bus_powered_pin, slow;
	logic [7:0] reg_addr, tx_data;
	logic [31:0] reg_wdata, reg_rdata;
	hcrh_setup_s req_setup;
	logic [3:0] minus_line_pin, plus_line_pin, port_disable, port_resume, port_power_off;
	hcrh_port_in_s [3:0] port_in;
	logic [15:0][7:0] rx_bytes;
	logic [4:0] rx_count, last_idx;
	logic [11:0] pulses;
	int failures, checked;

	hcrh_handler uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_setup(req_setup), .req_busy(req_busy),
		.req_stall(req_stall), .req_done(req_done), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.eof2_pulse(eof2_pulse), .minus_line_pin(minus_line_pin),
		.plus_line_pin(plus_line_pin), .local_pwr_good_pin(local_pwr_good_pin),
		.bus_powered_pin(bus_powered_pin), .port_in(port_in),
		.port_disable(port_disable), .port_resume(port_resume),
		.port_power_off(port_power_off));

	hcrh_host_model host (.mclk(mclk), .reset_n(reset_n), .start(req_valid),
		.slow(slow), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .rx_bytes(rx_bytes), .rx_count(rx_count), .last_idx(last_idx));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("failures=%0d checked=%0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_rx(input int n, input logic [15:0][7:0] e);
		chk_val("rx_count", n, {27'h0, rx_count});
		chk_val("tx_last", n - 1, {27'h0, last_idx});
		for (int i = 0; i < n; i++) begin
			chk_val("rx_byte", {24'h0, e[i]}, {24'h0, rx_bytes[i]});
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// one setup packet; waits for the stall or done pulse and judges which came
	task automatic do_req(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v,
		input logic [15:0] i, input logic [15:0] l, input logic stall_exp);
		int k;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_setup <= '{rt, rq, v, i, l};
		@(posedge mclk);
		req_valid <= 1'b0;
		#1;
		chk_val("req_busy", {31'h0, rt[7] && !stall_exp}, {31'h0, req_busy});
		for (k = 0; k < 60; k++) begin
			#1;
			if (req_stall === 1'b1 || req_done === 1'b1) break;
			@(posedge mclk);
		end
		pulses = {port_power_off, port_resume, port_disable};
		chk_val("req_stall", {31'h0, stall_exp}, {31'h0, k < 60 ? req_stall : 1'bx});
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk_val("reg_rdata", e, reg_rdata);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic t_desc();
		logic [15:0][7:0] e;
		e = '0;
		for (int i = 0; i < 9; i++) begin
			e[i] = HUB_DESC[i];
		end
		do_req(RT_HUB_IN, RQ_GET_DESC, 16'h2900, 16'h0000, 16'h0002, 1'b0);
		chk_rx(2, e);
		slow <= 1'b1;
		do_req(RT_HUB_IN, RQ_GET_DESC, 16'h2900, 16'h0000, 16'h000c, 1'b0);
		chk_rx(12, e);
		slow <= 1'b0;
	endtask

	task automatic t_hub();
		do_req(RT_HUB_IN, RQ_GET_STATUS, 16'h0, 16'h0, 16'h0004, 1'b0);
		chk_rx(4, 128'h0);
		local_pwr_good_pin <= 1'b0;
		tick(8);
		do_req(RT_HUB_IN, RQ_GET_STATUS, 16'h0, 16'h0, 16'h0004, 1'b0);
		chk_rx(4, 128'h00010001);
		reg_read(REG_HUB, 32'h00010001);
		do_req(RT_HUB_OUT, RQ_CLEAR_FEATURE, HSEL_LOCAL_PWR, 16'h0, 16'h0, 1'b0);
		do_req(RT_HUB_IN, RQ_GET_STATUS, 16'h0, 16'h0, 16'h0004, 1'b0);
		chk_rx(4, 128'h00000001);
		do_req(RT_HUB_OUT, RQ_CLEAR_FEATURE, HSEL_OVER_CUR, 16'h0, 16'h0, 1'b1);
		local_pwr_good_pin <= 1'b1;
		tick(8);
		reg_read(REG_HUB, 32'h00010000);
		// change bit left set and supply lost, so the bus powered masks can be seen
		bus_powered_pin <= 1'b1;
		local_pwr_good_pin <= 1'b0;
		tick(8);
		do_req(RT_HUB_IN, RQ_GET_STATUS, 16'h0, 16'h0, 16'h0004, 1'b0);
		chk_rx(4, 128'h0);
	endtask

	task automatic t_line();
		minus_line_pin <= 4'h5;
		plus_line_pin <= 4'h3;
		tick(8);
		eof2_pulse <= 1'b1;
		tick(1);
		eof2_pulse <= 1'b0;
		do_req(RT_PORT_IN, RQ_GET_BUS_STATE, 16'h0, 16'h0002, 16'h0001, 1'b0);
		chk_rx(1, 128'h02);
		minus_line_pin <= 4'ha;
		tick(8);
		reg_read(REG_LINE, 32'h00010203);
		reg_write(REG_CTRL, 32'h0);
		eof2_pulse <= 1'b1;
		tick(1);
		eof2_pulse <= 1'b0;
		reg_read(REG_LINE, 32'h00010203);
		reg_write(REG_CTRL, 32'h1);
		eof2_pulse <= 1'b1;
		tick(1);
		eof2_pulse <= 1'b0;
		reg_read(REG_LINE, 32'h01000302);
		reg_read(8'h10, 32'h0);
		do_req(RT_PORT_IN, RQ_GET_BUS_STATE, 16'h0, 16'h0000, 16'h0001, 1'b1);
		do_req(RT_PORT_IN, RQ_GET_BUS_STATE, 16'h0, 16'h0005, 16'h0001, 1'b1);
	endtask

	task automatic t_port();
		logic seen;
		logic [2:0][15:0] sel;
		sel = {PSEL_POWER, PSEL_SUSPEND, PSEL_ENABLE};
		seen = 1'b0;
		@(posedge mclk);
		port_in[2] <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		tick(1);
		port_in[2].resume_done <= 1'b0;
		port_in[2].reset_done <= 1'b0;
		repeat (4) begin
			#1;
			seen |= port_power_off[2];
			@(posedge mclk);
		end
		chk_val("power_off", 32'h1, {31'h0, seen});
		do_req(RT_PORT_IN, RQ_GET_STATUS, 16'h0, 16'h0003, 16'h0004, 1'b0);
		chk_rx(4, 128'h001f031b);
		do_req(RT_PORT_OUT, RQ_CLEAR_FEATURE, PSEL_C_FIRST, 16'h0003, 16'h0, 1'b0);
		do_req(RT_PORT_IN, RQ_GET_STATUS, 16'h0, 16'h0003, 16'h0004, 1'b0);
		chk_rx(4, 128'h001e031b);
		for (int j = 0; j < 3; j++) begin
			do_req(RT_PORT_OUT, RQ_CLEAR_FEATURE, sel[j], 16'h0003, 16'h0, 1'b0);
			chk_val("port_pulse", 32'h4 << (4 * j), {20'h0, pulses});
		end
		// reset completion arrives in the very cycle its clear is taken
		fork
			do_req(RT_PORT_OUT, RQ_CLEAR_FEATURE, PSEL_C_LAST, 16'h0003, 16'h0, 1'b0);
			begin
				tick(1);
				port_in[2].reset_done <= 1'b1;
				tick(1);
				port_in[2].reset_done <= 1'b0;
			end
		join
		do_req(RT_PORT_IN, RQ_GET_STATUS, 16'h0, 16'h0003, 16'h0004, 1'b0);
		chk_rx(4, 128'h001e031b);
		do_req(RT_PORT_OUT, RQ_CLEAR_FEATURE, 16'h0003, 16'h0003, 16'h0, 1'b1);
		do_req(RT_PORT_OUT, RQ_CLEAR_FEATURE, PSEL_ENABLE, 16'h0000, 16'h0, 1'b1);
		do_req(RT_PORT_OUT, RQ_CLEAR_FEATURE, PSEL_ENABLE, 16'h0005, 16'h0, 1'b1);
		do_req(RT_PORT_IN, RQ_GET_STATUS, 16'h0, 16'h0000, 16'h0004, 1'b1);
	endtask

	initial begin
		#100000;
		failures++;
		report_and_stop();
	end

	initial begin
		reset_n = 1'b0;
		{reg_wr, reg_rd, req_valid, eof2_pulse, bus_powered_pin, slow} = 6'h00;
		local_pwr_good_pin = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		req_setup = '0;
		minus_line_pin = 4'h0;
		plus_line_pin = 4'h0;
		port_in = '0;
		failures = 0;
		checked = 0;
		tick(6);
		reset_n <= 1'b1;
		tick(8);
		reg_read(REG_CTRL, 32'h1);
		t_desc();
		t_hub();
		t_line();
		t_port();
		report_and_stop();
	end
endmodule

`default_nettype wire
